// file: pewc_pkg.sv
`default_nettype none
package pewc_pkg;
  // Clock and pin timing
  localparam int CLK_NS = 10;
  localparam int CYCLE_TIME_NS = 150; // read access, slower grade
  localparam int CYCLE_TIME_CYC = (CYCLE_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int PULSE_NS = 100; // strobe low width, least
  localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int BLW_MIN_NS = 100; // byte_load_window least gap
  localparam int BLW_MIN_CYC = (BLW_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int BLW_MAX_US = 100; // byte_load_window longest
  localparam int BLW_MAX_CYC = BLW_MAX_US * 1000 / CLK_NS;
  localparam int PROG_MS = 5;
  localparam int PROG_CYC = PROG_MS * 1000000 / CLK_NS;
  localparam int INIT_MS = 10; // powerup_write_delay, longest
  localparam int INIT_CYC = INIT_MS * 1000000 / CLK_NS;
  localparam int PAGE_BYTES = 64;
  localparam int AW = 15;
  localparam int DW = 8;
  localparam int POLL_BIT = 7; // poll_status_bit
  localparam int FLIP_BIT = 6; // flip_status_bit
  localparam int BIP_W = 6; // byte_in_page_bits
  // Host commands
  typedef enum logic [1:0] {
    PEWC_CMD_READ = 2'h0,
    PEWC_CMD_WRITE = 2'h1,
    PEWC_CMD_LOCK = 2'h2,
    PEWC_CMD_UNLOCK = 2'h3
  } pewc_cmd_t;
  typedef struct packed {
    pewc_cmd_t cmd;
    logic [AW-1:0] addr;
    logic [DW-1:0] data;
    logic last; // final byte of a page load
  } pewc_req_t;
  // Memory pins as driven by the controller
  typedef struct packed {
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic [AW-1:0] addr;
    logic [DW-1:0] dq_o;
    logic dq_oe;
  } pewc_pins_t;
endpackage : pewc_pkg
`default_nettype wire

// file: pewc_timer.sv
`default_nettype none
// Down counter; done pulses one cycle when a loaded count expires
module pewc_timer #(
  parameter int W = 32
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic load,
  input wire logic [W-1:0] value,
  output logic done
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic run;
    logic done;
  } pewc_tmr_st_t;
  pewc_tmr_st_t st_r;
  pewc_tmr_st_t st_nxt;
  // Count down, pulse on reaching one
  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    if (load) begin
      st_nxt.cnt = value;
      st_nxt.run = 1'b1;
    end else if (st_r.run) begin
      if (st_r.cnt <= W'(1)) begin
        st_nxt.run = 1'b0;
        st_nxt.done = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt - W'(1);
      end
    end
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign done = st_r.done;
endmodule : pewc_timer
`default_nettype wire

// file: pewc_host.sv
`default_nettype none
module pewc_host
  import pewc_pkg::*;
#(
  parameter int INIT_CYCLES = INIT_CYC,
  parameter int PROG_CYCLES = PROG_CYC,
  parameter int WIN_CYCLES = BLW_MAX_CYC,
  parameter logic [AW-1:0] CMD_ADDR_A = 15'h0AAA, // arbitrary, set per part
  parameter logic [AW-1:0] CMD_ADDR_B = 15'h0555, // arbitrary, set per part
  parameter logic [DW-1:0] CMD_DATA_A = 8'hAA, // arbitrary
  parameter logic [DW-1:0] CMD_DATA_B = 8'h55, // arbitrary
  parameter logic [DW-1:0] CMD_LOCK = 8'hA0, // arbitrary
  parameter logic [DW-1:0] CMD_UNL1 = 8'h80, // arbitrary
  parameter logic [DW-1:0] CMD_UNL2 = 8'h20 // arbitrary
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic req_valid,
  input wire pewc_pkg::pewc_req_t req,
  input wire logic lock_on, // prefix writes with arming sequence
  output logic req_ready,
  output logic rsp_valid,
  output logic [DW-1:0] rsp_data,
  output logic write_done,
  output logic ce_n,
  output logic we_n,
  output logic oe_n,
  output logic [AW-1:0] addr,
  output logic [DW-1:0] dq_o,
  output logic dq_oe,
  input wire logic [DW-1:0] dq_i
);
  import pewc_pkg::*;

  typedef enum logic [6:0] {
    S_INIT = 7'h01,
    S_IDLE = 7'h02,
    S_RD = 7'h04,
    S_WLO = 7'h08,
    S_WHI = 7'h10,
    S_WAIT = 7'h20,
    S_POLL = 7'h40
  } pewc_state_t;

  typedef struct packed {
    pewc_state_t st;
    pewc_pins_t pins;
    logic [15:0] cnt;
    logic [2:0] seq; // command prefix step
    logic [2:0] seq_len;
    logic user_pending; // user byte still to follow prefix
    logic page_end; // last load of a page
    logic prev_flip;
    logic poll_first;
    logic rsp_valid;
    logic [DW-1:0] rsp_data;
    logic write_done;
    logic [DW-1:0] d1;
    logic [DW-1:0] d2;
  } pewc_st_t;

  pewc_st_t s_r;
  pewc_st_t s_nxt;
  pewc_req_t hold_r;
  pewc_req_t hold_nxt;
  logic [DW-1:0] dq_s1_r;
  logic [DW-1:0] dq_s2_r;
  logic init_load;
  logic init_done;
  logic win_load;
  logic win_done;
  logic init_seen_r;

  // Read data pin passes two flops before use
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dq_s1_r <= '0;
      dq_s2_r <= '0;
    end else begin
      dq_s1_r <= dq_i;
      dq_s2_r <= dq_s1_r;
    end
  end

  // Long waits share the timer; powerup delay, then load window; program time is polled, not timed
  assign init_load = (s_r.st == S_INIT) && !init_seen_r;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      init_seen_r <= 1'b0;
    end else if (init_load) begin
      init_seen_r <= 1'b1;
    end
  end
  // Every way into WAIT starts the window, a stalled page included, so WAIT never hangs
  assign win_load = init_load || (s_r.st == S_WHI && s_nxt.st == S_WAIT);
  pewc_timer #(.W(32)) u_timer (
    .clk(clk),
    .reset(reset),
    .load(win_load),
    .value(init_load ? 32'(INIT_CYCLES) : 32'(WIN_CYCLES)),
    .done(win_done)
  );
  assign init_done = win_done;

  // Command prefix byte for the current step
  function automatic logic [AW+DW-1:0] pfx(input logic [2:0] i, input logic [2:0] n);
    logic [AW+DW-1:0] r;
    r = {CMD_ADDR_A, CMD_DATA_A};
    case (i)
      3'h0: r = {CMD_ADDR_A, CMD_DATA_A};
      3'h1: r = {CMD_ADDR_B, CMD_DATA_B};
      3'h2: r = {CMD_ADDR_A, (n == 3'h3) ? CMD_LOCK : CMD_UNL1};
      3'h3: r = {CMD_ADDR_A, CMD_DATA_A};
      3'h4: r = {CMD_ADDR_B, CMD_DATA_B};
      default: r = {CMD_ADDR_A, CMD_UNL2};
    endcase
    return r;
  endfunction : pfx

  // Main sequencer
  always_comb begin
    s_nxt = s_r;
    hold_nxt = hold_r;
    s_nxt.rsp_valid = 1'b0;
    s_nxt.write_done = 1'b0;
    if (s_r.cnt != 16'h0000) begin
      s_nxt.cnt = s_r.cnt - 16'h0001;
    end
    case (s_r.st)
      S_INIT: begin
        if (init_done) begin
          s_nxt.st = S_IDLE;
        end
      end
      S_IDLE: begin
        s_nxt.pins.ce_n = 1'b1;
        s_nxt.pins.oe_n = 1'b1;
        s_nxt.pins.we_n = 1'b1;
        s_nxt.pins.dq_oe = 1'b0;
        if (req_valid) begin
          hold_nxt = req;
          s_nxt.seq = 3'h0;
          s_nxt.user_pending = 1'b0;
          s_nxt.page_end = 1'b0;
          s_nxt.pins.addr = req.addr;
          if (req.cmd == PEWC_CMD_READ) begin
            s_nxt.st = S_RD;
            s_nxt.pins.ce_n = 1'b0;
            s_nxt.pins.oe_n = 1'b0;
            s_nxt.cnt = 16'(CYCLE_TIME_CYC + 2);
          end else begin
            // Prefix lengths: 3 to arm, 6 to disarm, none when unlocked
            s_nxt.seq_len = (req.cmd == PEWC_CMD_UNLOCK) ? 3'h6 :
              (req.cmd == PEWC_CMD_LOCK || lock_on) ? 3'h3 : 3'h0;
            s_nxt.user_pending = (req.cmd == PEWC_CMD_WRITE);
            s_nxt.st = S_WLO;
            s_nxt.cnt = 16'(PULSE_CYC);
            if (s_nxt.seq_len == 3'h0) begin
              s_nxt.user_pending = 1'b0;
              s_nxt.page_end = req.last;
              {s_nxt.pins.addr, s_nxt.pins.dq_o} = {req.addr, req.data};
            end else begin
              {s_nxt.pins.addr, s_nxt.pins.dq_o} = pfx(3'h0, s_nxt.seq_len);
              s_nxt.page_end = (s_nxt.seq_len == 3'h1) && !s_nxt.user_pending;
            end
            // Gate high before select and strobe fall, so the cycle is a write
            s_nxt.pins.oe_n = 1'b1;
            s_nxt.pins.ce_n = 1'b0;
            s_nxt.pins.we_n = 1'b0;
            s_nxt.pins.dq_oe = 1'b1;
          end
        end
      end
      S_RD: begin
        if (s_r.cnt == 16'h0001) begin
          s_nxt.rsp_valid = 1'b1;
          s_nxt.rsp_data = dq_s2_r;
          s_nxt.pins.ce_n = 1'b1;
          s_nxt.pins.oe_n = 1'b1;
          s_nxt.st = S_IDLE;
        end
      end
      S_WLO: begin
        // Strobe held low well beyond the noise filter width
        if (s_r.cnt == 16'h0001) begin
          s_nxt.pins.we_n = 1'b1;
          s_nxt.st = S_WHI;
          s_nxt.cnt = 16'(BLW_MIN_CYC);
        end
      end
      S_WHI: begin
        if (s_r.cnt == 16'h0001) begin
          s_nxt.pins.ce_n = 1'b1;
          s_nxt.pins.dq_oe = 1'b0;
          if (s_r.page_end) begin
            s_nxt.st = S_WAIT;
          end else if (s_r.seq + 3'h1 < s_r.seq_len) begin
            // Next prefix byte inside the load window
            s_nxt.seq = s_r.seq + 3'h1;
            {s_nxt.pins.addr, s_nxt.pins.dq_o} = pfx(s_nxt.seq, s_r.seq_len);
            s_nxt.page_end = (s_nxt.seq + 3'h1 == s_r.seq_len) && !s_r.user_pending;
            s_nxt.pins.ce_n = 1'b0;
            s_nxt.pins.we_n = 1'b0;
            s_nxt.pins.dq_oe = 1'b1;
            s_nxt.st = S_WLO;
            s_nxt.cnt = 16'(PULSE_CYC);
          end else if (s_r.user_pending) begin
            s_nxt.user_pending = 1'b0;
            s_nxt.seq = s_r.seq_len;
            {s_nxt.pins.addr, s_nxt.pins.dq_o} = {hold_r.addr, hold_r.data};
            s_nxt.page_end = hold_r.last;
            s_nxt.pins.ce_n = 1'b0;
            s_nxt.pins.we_n = 1'b0;
            s_nxt.pins.dq_oe = 1'b1;
            s_nxt.st = S_WLO;
            s_nxt.cnt = 16'(PULSE_CYC);
          end else if (req_valid && req.cmd == PEWC_CMD_WRITE) begin
            // Further page loads; low bits any order, page from final load
            hold_nxt = req;
            {s_nxt.pins.addr, s_nxt.pins.dq_o} = {req.addr, req.data};
            s_nxt.page_end = req.last;
            s_nxt.pins.ce_n = 1'b0;
            s_nxt.pins.we_n = 1'b0;
            s_nxt.pins.dq_oe = 1'b1;
            s_nxt.st = S_WLO;
            s_nxt.cnt = 16'(PULSE_CYC);
          end else begin
            s_nxt.st = S_WAIT; // user stalled: end the page safely
          end
          s_nxt.d1 = s_r.pins.dq_o;
        end
      end
      S_WAIT: begin
        // Strobe stays high a full window so the program cycle begins
        if (win_done) begin
          s_nxt.st = S_POLL;
          s_nxt.poll_first = 1'b1;
          s_nxt.pins.ce_n = 1'b0;
          s_nxt.pins.oe_n = 1'b0;
          s_nxt.cnt = 16'(CYCLE_TIME_CYC + 2);
        end
      end
      S_POLL: begin
        // Toggle and data polling; no writes issued while device programs
        if (s_r.cnt == 16'h0001) begin
          s_nxt.pins.ce_n = 1'b1;
          s_nxt.pins.oe_n = 1'b1;
          s_nxt.prev_flip = dq_s2_r[FLIP_BIT];
          s_nxt.poll_first = 1'b0;
          if (!s_r.poll_first && dq_s2_r[FLIP_BIT] == s_r.prev_flip
              && dq_s2_r[POLL_BIT] == s_r.d1[POLL_BIT]) begin
            s_nxt.write_done = 1'b1;
            s_nxt.st = S_IDLE;
          end
        end else if (s_r.cnt == 16'h0000) begin
          s_nxt.pins.ce_n = 1'b0;
          s_nxt.pins.oe_n = 1'b0;
          s_nxt.cnt = 16'(CYCLE_TIME_CYC + 2);
        end
      end
      default: s_nxt.st = S_INIT;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_r <= '{st: S_INIT, pins: '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, default: '0}, default: '0};
      hold_r <= '0;
    end else begin
      s_r <= s_nxt;
      hold_r <= hold_nxt;
    end
  end

  assign ce_n = s_r.pins.ce_n;
  assign we_n = s_r.pins.we_n;
  assign oe_n = s_r.pins.oe_n;
  assign addr = s_r.pins.addr;
  assign dq_o = s_r.pins.dq_o;
  assign dq_oe = s_r.pins.dq_oe;
  assign rsp_valid = s_r.rsp_valid;
  assign rsp_data = s_r.rsp_data;
  assign write_done = s_r.write_done;
  assign req_ready = s_r.st[1]; // One-hot idle bit, straight from the flop

  // Strobe low run length; saturates, only the pulse width check reads it
  logic [4:0] low_run_r;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      low_run_r <= 5'h00;
    end else if (we_n) begin
      low_run_r <= 5'h00;
    end else if (low_run_r != 5'h1F) begin
      low_run_r <= low_run_r + 5'h01;
    end
  end

  // Checks
  AST_NO_CONTENTION: assert property (@(posedge clk) disable iff (reset)
    !(dq_oe && !oe_n)) else $error("data driven while output gate low");
  AST_WRITE_GATE: assert property (@(posedge clk) disable iff (reset)
    $fell(we_n) |-> oe_n && !ce_n) else $error("strobe fell without write setup");
  AST_PULSE_WIDTH: assert property (@(posedge clk) disable iff (reset)
    $rose(we_n) |-> low_run_r >= 5'(PULSE_CYC)) else $error("write pulse too short");
  AST_NO_INIT_WRITE: assert property (@(posedge clk) disable iff (reset)
    s_r.st == S_INIT |-> we_n) else $error("write during powerup delay");
  AST_DATA_HELD: assert property (@(posedge clk) disable iff (reset)
    $rose(we_n) |-> dq_oe && $stable(dq_o)) else $error("data changed at strobe rise");
  AST_POLL_NO_WRITE: assert property (@(posedge clk) disable iff (reset)
    s_r.st == S_POLL |-> we_n && !dq_oe) else $error("write during programming");
  AST_ADDR_STABLE: assert property (@(posedge clk) disable iff (reset)
    !we_n && $past(!we_n) |-> $stable(addr)) else $error("address moved in pulse");
  AST_READ_GATE: assert property (@(posedge clk) disable iff (reset)
    !oe_n |-> we_n && !ce_n) else $error("read with strobe low");
  COV_READ: cover property (@(posedge clk) rsp_valid);
  COV_DONE: cover property (@(posedge clk) write_done);
  COV_PREFIX: cover property (@(posedge clk) s_r.st == S_WLO && s_r.seq == 3'h5);
endmodule : pewc_host
`default_nettype wire

// file: pewc_mem_model.sv
`default_nettype none
// Behavioural memory device seen through the host pins
module pewc_mem_model
  import pewc_pkg::*;
#(
  parameter int INIT_C = 50,
  parameter int WIN_C = 40,
  parameter int PROG_C = 50,
  parameter logic [AW-1:0] CA = 15'h0AAA, // arbitrary, same as host
  parameter logic [AW-1:0] CB = 15'h0555, // arbitrary, same as host
  parameter logic [DW-1:0] DA = 8'hAA,
  parameter logic [DW-1:0] DB = 8'h55,
  parameter logic [DW-1:0] LK = 8'hA0,
  parameter logic [DW-1:0] U1 = 8'h80,
  parameter logic [DW-1:0] U2 = 8'h20
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] dq_o,
  input wire logic dq_oe,
  output logic [DW-1:0] dq_bus
);
  import pewc_pkg::*;
  localparam logic [AW+DW-1:0] ARM [3] = '{{CA, DA}, {CB, DB}, {CA, LK}};
  localparam logic [AW+DW-1:0] UNL [6] = '{{CA, DA}, {CB, DB}, {CA, U1}, {CA, DA}, {CB, DB}, {CA, U2}};
  logic [DW-1:0] mem [0:(1<<AW)-1];
  logic [DW-1:0] pg_d [0:PAGE_BYTES-1];
  logic [PAGE_BYTES-1:0] pg_v;
  logic [AW-1:0] lat_a;
  logic [AW-BIP_W-1:0] pg_sel;
  logic [DW-1:0] last_d, prev_bus, rd_val;
  logic wr_on, wr_q, rd_on, rd_q, tog, lock_r, hit_a, hit_u, busy;
  int init_cnt, win_cnt, prog_cnt, low_cnt, ai, ui;

  // Shipped unlocked; contents seeded from the address
  initial begin
    lock_r = 1'b0;
    for (int i = 0; i < (1 << AW); i++) mem[i] = DW'(i) ^ 8'h5A;
  end

  // Pin decode and status reads
  assign wr_on = !ce_n && !we_n && oe_n;
  assign rd_on = !ce_n && !oe_n && we_n;
  assign busy = prog_cnt != 0;
  assign hit_a = ai < 3 && {lat_a, dq_o} == ARM[ai];
  assign hit_u = ui < 6 && {lat_a, dq_o} == UNL[ui];
  assign rd_val = busy ? {~last_d[POLL_BIT], tog, 6'h15} : mem[addr];
  // Released bus flips each cycle so a stale value never passes
  assign dq_bus = dq_oe ? dq_o : (rd_on ? rd_val : ~prev_bus);

  // Loads, window timer, program cycle; lock and array survive reset
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      init_cnt <= INIT_C;
      {win_cnt, prog_cnt, low_cnt, ai, ui} <= '0;
      {pg_v, wr_q, rd_q, tog, prev_bus} <= '0;
    end else begin
      prev_bus <= dq_bus;
      wr_q <= wr_on;
      rd_q <= rd_on;
      low_cnt <= wr_on ? low_cnt + 1 : 0;
      if (init_cnt > 0) init_cnt <= init_cnt - 1;
      if (rd_on && !rd_q) tog <= !tog;
      if (wr_on && !wr_q) lat_a <= addr;
      if (wr_on && !wr_q) win_cnt <= 0;
      else if (!wr_on && wr_q && low_cnt >= 2 && init_cnt == 0 && !busy) begin
        pg_d[lat_a[BIP_W-1:0]] <= dq_o;
        pg_v[lat_a[BIP_W-1:0]] <= 1'b1;
        pg_sel <= lat_a[AW-1:BIP_W];
        last_d <= dq_o;
        win_cnt <= WIN_C;
        ai <= hit_a ? ai + 1 : ai;
        ui <= hit_u ? ui + 1 : ui;
        if (hit_a && ai == 2) lock_r <= 1'b1;
        if (hit_u && ui == 5) lock_r <= 1'b0;
      end else if (win_cnt == 1) begin
        if (!lock_r || ai == 3 || ui == 6) prog_cnt <= PROG_C;
        else pg_v <= '0;
        {win_cnt, ai, ui} <= '0;
      end else if (win_cnt > 1) win_cnt <= win_cnt - 1;
      if (prog_cnt == 1) begin
        for (int i = 0; i < PAGE_BYTES; i++) if (pg_v[i]) mem[{pg_sel, BIP_W'(i)}] <= pg_d[i];
        pg_v <= '0;
      end
      if (prog_cnt > 0) prog_cnt <= prog_cnt - 1;
    end
  end
endmodule : pewc_mem_model
`default_nettype wire

// file: tb.sv
`default_nettype none
// Host controller against the behavioural memory
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pewc_pkg::*;
  localparam int INIT_C = 50;
  localparam int WIN_C = 40;
  localparam int PROG_C = 50;
  logic clk, reset, req_valid, lock_on, req_ready, rsp_valid, write_done;
  logic ce_n, we_n, oe_n, dq_oe;
  logic [AW-1:0] addr;
  logic [DW-1:0] rsp_data, dq_o, dq_bus;
  pewc_req_t req;
  int num_errors = 0;
  int cmp_count = 0;

  pewc_host #(.INIT_CYCLES(INIT_C), .PROG_CYCLES(PROG_C), .WIN_CYCLES(WIN_C)) dut (
    .clk(clk), .reset(reset), .req_valid(req_valid), .req(req), .lock_on(lock_on),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .write_done(write_done),
    .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .addr(addr), .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_bus));
  pewc_mem_model #(.INIT_C(INIT_C), .WIN_C(WIN_C), .PROG_C(PROG_C)) model (
    .clk(clk), .reset(reset), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .addr(addr),
    .dq_o(dq_o), .dq_oe(dq_oe), .dq_bus(dq_bus));

  function automatic logic [DW-1:0] seed(input logic [AW-1:0] a);
    return a[DW-1:0] ^ 8'h5A;
  endfunction : seed

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk

  task automatic conclude();
    $display("checks %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude

  // Bounded waits; outputs are sampled at the falling edge
  task automatic idle_wait();
    int k;
    k = 0;
    while (req_ready !== 1'b1 && k < 3000) begin
      @(negedge clk);
      k++;
    end
    chk("ready", k < 3000, 1);
  endtask : idle_wait

  task automatic wait_done(output int k);
    k = 0;
    while (write_done !== 1'b1 && k < 5000) begin
      @(negedge clk);
      k++;
    end
    chk("write done", k < 5000, 1);
  endtask : wait_done

  // One load; valid held until the strobe of this load falls
  task automatic load(input pewc_cmd_t c, input logic [AW-1:0] a, input logic [DW-1:0] d,
                      input logic l, input logic lk);
    int k;
    k = 0;
    @(posedge clk);
    req_valid <= 1'b1;
    lock_on <= lk;
    req <= '{cmd: c, addr: a, data: d, last: l};
    @(negedge clk);
    while (we_n !== 1'b1 && k < 200) begin
      @(negedge clk);
      k++;
    end
    while (we_n !== 1'b0 && k < 200) begin
      @(negedge clk);
      k++;
    end
    @(posedge clk);
    req_valid <= 1'b0;
    chk("load taken", k < 200, 1);
  endtask : load

  task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] exp);
    int k;
    idle_wait();
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{cmd: PEWC_CMD_READ, addr: a, data: 8'h00, last: 1'b0};
    @(posedge clk);
    req_valid <= 1'b0;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (rsp_valid !== 1'b1 && k < 100);
    // Pulse lands 17 edges after the take, first seen at the 18th falling edge
    chk("read latency", k, 18);
    chk("read data", rsp_data, exp);
  endtask : rd

  // No strobe and no ready inside the power-up delay
  task automatic t_init();
    int k;
    logic strobed;
    k = 0;
    strobed = 1'b0;
    while (req_ready !== 1'b1 && k < 1000) begin
      @(negedge clk);
      k++;
      strobed |= we_n === 1'b0;
    end
    chk("powerup delay", k >= INIT_C, 1);
    chk("strobe in delay", strobed, 0);
    $display("test init done");
  endtask : t_init

  task automatic t_byte();
    int k;
    rd(15'h1234, seed(15'h1234));
    idle_wait();
    load(PEWC_CMD_WRITE, 15'h0107, 8'hC3, 1'b1, 1'b0);
    wait_done(k);
    chk("program not early", k >= WIN_C + PROG_C, 1);
    rd(15'h0107, 8'hC3);
    rd(15'h0108, seed(15'h0108));
    $display("test byte done");
  endtask : t_byte

  // Out-of-order loads; the final load names the page
  task automatic t_page();
    int k;
    idle_wait();
    load(PEWC_CMD_WRITE, 15'h7E09, 8'h11, 1'b0, 1'b0);
    load(PEWC_CMD_WRITE, 15'h1102, 8'h22, 1'b0, 1'b0);
    load(PEWC_CMD_WRITE, 15'h0245, 8'h33, 1'b1, 1'b0);
    wait_done(k);
    rd(15'h0249, 8'h11);
    rd(15'h0242, 8'h22);
    rd(15'h0245, 8'h33);
    rd(15'h0243, seed(15'h0243));
    rd(15'h7E09, seed(15'h7E09));
    $display("test page done");
  endtask : t_page

  // Arm, prefixed write, reset, disarm, plain write
  task automatic t_lock();
    int k;
    idle_wait();
    load(PEWC_CMD_LOCK, 15'h0000, 8'h00, 1'b1, 1'b0);
    wait_done(k);
    chk("lock armed", model.lock_r, 1);
    idle_wait();
    load(PEWC_CMD_WRITE, 15'h0311, 8'h96, 1'b1, 1'b1);
    wait_done(k);
    rd(15'h0311, 8'h96);
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    t_init();
    chk("lock kept", model.lock_r, 1);
    load(PEWC_CMD_UNLOCK, 15'h0000, 8'h00, 1'b1, 1'b0);
    wait_done(k);
    chk("lock cleared", model.lock_r, 0);
    idle_wait();
    load(PEWC_CMD_WRITE, 15'h0322, 8'h4B, 1'b1, 1'b0);
    wait_done(k);
    rd(15'h0322, 8'h4B);
    $display("test lock done");
  endtask : t_lock

  // Free-running clock
  always #5 clk = ~clk;

  // Reset, then the scenarios in order
  initial begin
    clk = 1'b0;
    reset = 1'b1;
    req_valid = 1'b0;
    lock_on = 1'b0;
    req = '0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    t_init();
    t_byte();
    t_page();
    t_lock();
    conclude();
  end

  // Watchdog, over ten times the fewer than 2000 cycles the run needs
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    $display("watchdog expired");
    conclude();
  end
endmodule : tb
`default_nettype wire
